// ### logic/mie_pkg.sv
// package: constants, opcodes and state carrier of the execution datapath subset
package mie_pkg;

	// apb byte addresses of the registers
	localparam logic [7:0] MIE_OFS_EXEC = 8'h00;
	localparam logic [7:0] MIE_OFS_WORK = 8'h04;
	localparam logic [7:0] MIE_OFS_STAT = 8'h08;
	localparam logic [7:0] MIE_OFS_TPTR = 8'h0C;
	localparam logic [7:0] MIE_OFS_THI = 8'h10;
	localparam logic [7:0] MIE_OFS_PAGE = 8'h14;
	localparam logic [7:0] MIE_OFS_MADR = 8'h18;
	localparam logic [7:0] MIE_OFS_MDAT = 8'h1C;

	// exec register field positions
	localparam int MIE_EX_OP_LSB = 0;
	localparam int MIE_EX_ADR_LSB = 4;
	localparam int MIE_EX_BIT_LSB = 12;
	localparam int MIE_EX_IMM_LSB = 16;

	// status register bit positions
	localparam int MIE_ST_C = 0;
	localparam int MIE_ST_AC = 1;
	localparam int MIE_ST_Z = 2;
	localparam int MIE_ST_OV = 3;
	localparam int MIE_ST_BUSY = 4;
	localparam int MIE_ST_SKIP = 5;

	// widths and reset values
	localparam int MIE_PAGE_W = 4;
	localparam int MIE_PWORD_W = 15;
	localparam logic [7:0] MIE_BYTE_RST = 8'h00;
	localparam logic [MIE_PAGE_W-1:0] MIE_LAST_PAGE = 4'hF;
	localparam logic [31:0] MIE_RD_ZERO = 32'h0000_0000;

	// operation codes written into the exec register
	typedef enum logic [3:0] {
		MIE_OP_NOP = 4'h0,
		MIE_OP_SUB_MEM = 4'h1,
		MIE_OP_SUB_IMM = 4'h2,
		MIE_OP_SWAP_MEM = 4'h3,
		MIE_OP_SWAP_WORK = 4'h4,
		MIE_OP_SKIP_NULL = 4'h5,
		MIE_OP_COPY_SKIP = 4'h6,
		MIE_OP_BIT_SKIP = 4'h7,
		MIE_OP_TBL_CUR = 4'h8,
		MIE_OP_TBL_LAST = 4'h9,
		MIE_OP_XOR_WORK = 4'hA,
		MIE_OP_XOR_MEM = 4'hB,
		MIE_OP_XOR_IMM = 4'hC
	} mie_op_t;

	typedef enum logic [1:0] {
		MIE_ST_IDLE,
		MIE_ST_EXEC,
		MIE_ST_TWAIT,
		MIE_ST_DUMMY
	} mie_state_t;

	// status flags
	typedef struct packed {
		logic ov;
		logic z;
		logic ac;
		logic c;
	} mie_flags_t;

	// decoded instruction
	typedef struct packed {
		mie_op_t op;
		logic [7:0] adr;
		logic [2:0] bsel;
		logic [7:0] imm;
	} mie_instr_t;

	// apb slave inputs
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} mie_apb_req_t;

	// apb slave answer
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} mie_apb_rsp_t;

	// whole state of the datapath
	typedef struct packed {
		mie_state_t st;
		mie_instr_t ins;
		logic [7:0] work;
		mie_flags_t fl;
		logic [7:0] tptr;
		logic [6:0] thi;
		logic [MIE_PAGE_W-1:0] page;
		logic [7:0] madr;
		logic skip_pulse;
		logic last_skip;
		logic [MIE_PAGE_W+7:0] paddr;
		logic prd;
	} mie_regs_t;

endpackage

// ### logic/mie_exec.sv
// module: execution datapath for subtract, swap, zero skip, table read and xor
//
// Decided for this implementation: the register addresses and the APB register port.

// How it works
// - memory subtract: work plus inverted byte plus one, back to memory, four flags
// - immediate subtract: work plus inverted immediate plus one into work, four flags
// - memory swap exchanges nibbles of the addressed byte, flags kept
// - swap to work: upper nibble to low bits, lower to high, memory kept
// - skip on null byte: discard next, dummy cycle, two cycles; else one
// - copy byte into work, skip with dummy cycle when it is zero
// - bit test skips with dummy cycle when selected bit is zero, flags kept
// - current page table read: low byte to memory, high part to high latch
// - last page table read: same, but from the final page
// - xor work with memory byte into work, only zero flag changes
// - xor memory byte with work back into memory, only zero flag
// - xor work with immediate into work, only zero flag
module mie_exec #(
	parameter int DMEM_DEPTH = 224
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// apb slave
	input wire mie_pkg::mie_apb_req_t apb_i,
	output mie_pkg::mie_apb_rsp_t apb_o,
	// program memory read port, data one cycle after the strobe
	output logic [mie_pkg::MIE_PAGE_W+7:0] prog_addr_o,
	output logic prog_rd_o,
	input wire logic [mie_pkg::MIE_PWORD_W-1:0] prog_data_i,
	// sequencing status
	output logic skip_o,
	output logic dummy_o,
	output logic busy_o
);
	import mie_pkg::*;

	mie_regs_t r_q;
	mie_regs_t r_d;
	logic [7:0] dmem [DMEM_DEPTH];

	logic mem_we;
	logic [7:0] mem_wa;
	logic [7:0] mem_wd;

	// operand byte, read at the instruction address; out of range reads zero
	logic [7:0] opnd;
	logic [7:0] apb_mem;
	always_comb begin
		opnd = MIE_BYTE_RST;
		apb_mem = MIE_BYTE_RST;
		if (int'(r_q.ins.adr) < DMEM_DEPTH) begin
			opnd = dmem[r_q.ins.adr];
		end
		if (int'(r_q.madr) < DMEM_DEPTH) begin
			apb_mem = dmem[r_q.madr];
		end
	end

	// subtract as addition of the inverted operand plus one
	logic [7:0] sub_b;
	logic [8:0] sub_sum;
	logic [4:0] sub_lo;
	mie_flags_t sub_fl;
	always_comb begin
		sub_b = (r_q.ins.op == MIE_OP_SUB_IMM) ? ~r_q.ins.imm : ~opnd;
		sub_sum = {1'b0, r_q.work} + {1'b0, sub_b} + 9'h001;
		sub_lo = {1'b0, r_q.work[3:0]} + {1'b0, sub_b[3:0]} + 5'h01;
		sub_fl.c = sub_sum[8];
		sub_fl.ac = sub_lo[4];
		// overflow when both addends share a sign the result does not
		sub_fl.ov = (r_q.work[7] == sub_b[7]) && (sub_sum[7] != r_q.work[7]);
		sub_fl.z = (sub_sum[7:0] == MIE_BYTE_RST);
	end

	// apb decode; every access waits while an instruction is in flight
	logic acc;
	logic wr;
	logic mapped;
	always_comb begin
		acc = apb_i.psel && apb_i.penable && (r_q.st == MIE_ST_IDLE);
		wr = acc && apb_i.pwrite;
		// one item per register so a new offset cannot be forgotten here
		case (apb_i.paddr)
			MIE_OFS_EXEC: begin
				mapped = 1'b1;
			end
			MIE_OFS_WORK: begin
				mapped = 1'b1;
			end
			MIE_OFS_STAT: begin
				mapped = 1'b1;
			end
			MIE_OFS_TPTR: begin
				mapped = 1'b1;
			end
			MIE_OFS_THI: begin
				mapped = 1'b1; // read only, writes are dropped
			end
			MIE_OFS_PAGE: begin
				mapped = 1'b1;
			end
			MIE_OFS_MADR: begin
				mapped = 1'b1;
			end
			MIE_OFS_MDAT: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
		apb_o.pready = (r_q.st == MIE_ST_IDLE);
		apb_o.pslverr = apb_o.pready && apb_i.psel && apb_i.penable && !mapped;
		apb_o.prdata = MIE_RD_ZERO;
		if (acc && !apb_i.pwrite) begin
			case (apb_i.paddr)
				MIE_OFS_WORK: begin
					apb_o.prdata[7:0] = r_q.work;
				end
				MIE_OFS_STAT: begin
					apb_o.prdata[MIE_ST_C] = r_q.fl.c;
					apb_o.prdata[MIE_ST_AC] = r_q.fl.ac;
					apb_o.prdata[MIE_ST_Z] = r_q.fl.z;
					apb_o.prdata[MIE_ST_OV] = r_q.fl.ov;
					apb_o.prdata[MIE_ST_BUSY] = 1'b0;
					apb_o.prdata[MIE_ST_SKIP] = r_q.last_skip;
				end
				MIE_OFS_TPTR: begin
					apb_o.prdata[7:0] = r_q.tptr;
				end
				MIE_OFS_THI: begin
					apb_o.prdata[6:0] = r_q.thi;
				end
				MIE_OFS_PAGE: begin
					apb_o.prdata[MIE_PAGE_W-1:0] = r_q.page;
				end
				MIE_OFS_MADR: begin
					apb_o.prdata[7:0] = r_q.madr;
				end
				MIE_OFS_MDAT: begin
					apb_o.prdata[7:0] = apb_mem; // memory byte at the pointer
				end
				default: begin
					apb_o.prdata = MIE_RD_ZERO;
				end
			endcase
		end
	end

	// next state: register writes, instruction sequencing, datapath results
	logic [7:0] xr;
	logic do_skip;
	always_comb begin
		r_d = r_q;
		r_d.skip_pulse = 1'b0;
		r_d.prd = 1'b0;
		mem_we = 1'b0;
		mem_wa = r_q.ins.adr;
		mem_wd = MIE_BYTE_RST;
		xr = r_q.work ^ ((r_q.ins.op == MIE_OP_XOR_IMM) ? r_q.ins.imm : opnd);
		do_skip = 1'b0;
		if (wr) begin
			case (apb_i.paddr)
				MIE_OFS_EXEC: begin
					r_d.ins.op = mie_op_t'(apb_i.pwdata[MIE_EX_OP_LSB +: 4]);
					r_d.ins.adr = apb_i.pwdata[MIE_EX_ADR_LSB +: 8];
					r_d.ins.bsel = apb_i.pwdata[MIE_EX_BIT_LSB +: 3];
					r_d.ins.imm = apb_i.pwdata[MIE_EX_IMM_LSB +: 8];
					r_d.st = MIE_ST_EXEC;
				end
				MIE_OFS_WORK: begin
					r_d.work = apb_i.pwdata[7:0];
				end
				MIE_OFS_STAT: begin
					r_d.fl.c = apb_i.pwdata[MIE_ST_C];
					r_d.fl.ac = apb_i.pwdata[MIE_ST_AC];
					r_d.fl.z = apb_i.pwdata[MIE_ST_Z];
					r_d.fl.ov = apb_i.pwdata[MIE_ST_OV];
				end
				MIE_OFS_TPTR: begin
					r_d.tptr = apb_i.pwdata[7:0];
				end
				MIE_OFS_PAGE: begin
					r_d.page = apb_i.pwdata[MIE_PAGE_W-1:0];
				end
				MIE_OFS_MADR: begin
					r_d.madr = apb_i.pwdata[7:0];
				end
				MIE_OFS_MDAT: begin
					mem_we = 1'b1;
					mem_wa = r_q.madr;
					mem_wd = apb_i.pwdata[7:0];
				end
				default: begin
					r_d.st = r_q.st; // high latch and unmapped: no effect
				end
			endcase
		end
		case (r_q.st)
			MIE_ST_IDLE: begin
				r_d.skip_pulse = 1'b0;
			end
			MIE_ST_EXEC: begin
				r_d.st = MIE_ST_IDLE;
				case (r_q.ins.op)
					MIE_OP_SUB_MEM: begin
						mem_we = 1'b1;
						mem_wd = sub_sum[7:0];
						r_d.fl = sub_fl;
					end
					MIE_OP_SUB_IMM: begin
						r_d.work = sub_sum[7:0];
						r_d.fl = sub_fl;
					end
					MIE_OP_SWAP_MEM: begin
						mem_we = 1'b1;
						mem_wd = {opnd[3:0], opnd[7:4]};
					end
					MIE_OP_SWAP_WORK: begin
						r_d.work = {opnd[3:0], opnd[7:4]};
					end
					MIE_OP_SKIP_NULL: begin
						do_skip = (opnd == MIE_BYTE_RST);
					end
					MIE_OP_COPY_SKIP: begin
						r_d.work = opnd;
						do_skip = (opnd == MIE_BYTE_RST);
					end
					MIE_OP_BIT_SKIP: begin
						do_skip = !opnd[r_q.ins.bsel];
					end
					MIE_OP_TBL_CUR: begin
						r_d.paddr = {r_q.page, r_q.tptr};
						r_d.prd = 1'b1;
						r_d.st = MIE_ST_TWAIT;
					end
					MIE_OP_TBL_LAST: begin
						r_d.paddr = {MIE_LAST_PAGE, r_q.tptr};
						r_d.prd = 1'b1;
						r_d.st = MIE_ST_TWAIT;
					end
					MIE_OP_XOR_WORK, MIE_OP_XOR_IMM: begin
						r_d.work = xr;
						r_d.fl.z = (xr == MIE_BYTE_RST);
					end
					MIE_OP_XOR_MEM: begin
						mem_we = 1'b1;
						mem_wd = xr;
						r_d.fl.z = (xr == MIE_BYTE_RST);
					end
					default: begin
						r_d.st = MIE_ST_IDLE; // unused codes act as a one cycle no-op
					end
				endcase
				// the fetched next instruction is thrown away and one dummy cycle follows
				if (do_skip) begin
					r_d.skip_pulse = 1'b1;
					r_d.st = MIE_ST_DUMMY;
				end
				r_d.last_skip = do_skip;
			end
			MIE_ST_TWAIT: begin
				// the strobe cycle passes first; the rom word is valid one cycle later
				if (!r_q.prd) begin
					// low byte to memory, upper seven bits latched
					mem_we = 1'b1;
					mem_wd = prog_data_i[7:0];
					r_d.thi = prog_data_i[MIE_PWORD_W-1:8];
					r_d.st = MIE_ST_IDLE;
				end
			end
			MIE_ST_DUMMY: begin
				r_d.st = MIE_ST_IDLE;
			end
			default: begin
				r_d.st = MIE_ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	// data memory has no reset: contents are undefined until written
	always_ff @(posedge clk_i) begin
		if (mem_we && (int'(mem_wa) < DMEM_DEPTH)) begin
			dmem[mem_wa] <= mem_wd;
		end
	end

	// outputs from state flops; address, strobe and skip direct, dummy and busy decoded from the state
	assign prog_addr_o = r_q.paddr;
	assign prog_rd_o = r_q.prd;
	assign skip_o = r_q.skip_pulse;
	assign dummy_o = (r_q.st == MIE_ST_DUMMY);
	assign busy_o = (r_q.st != MIE_ST_IDLE);

endmodule

// ### verif/mie_exec_sva.sv
// checker: port timing properties of the execution datapath
module mie_exec_sva import mie_pkg::*; #(
	parameter int DMEM_DEPTH = 224
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// watched ports
	input wire mie_apb_req_t apb_i,
	input wire mie_apb_rsp_t apb_o,
	input wire logic [MIE_PAGE_W+7:0] prog_addr_o,
	input wire logic prog_rd_o,
	input wire logic [MIE_PWORD_W-1:0] prog_data_i,
	input wire logic skip_o,
	input wire logic dummy_o,
	input wire logic busy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	logic ex;
	logic [3:0] op;
	// an exec write is taken at this edge
	assign ex = apb_i.psel && apb_i.penable && apb_o.pready && apb_i.pwrite
		&& apb_i.paddr == MIE_OFS_EXEC;
	assign op = apb_i.pwdata[3:0];
	ready_busy_a: assert property (busy_o |-> !apb_o.pready) else $error("pready while busy");
	alu_timing_a: assert property (
		ex && op inside {1, 2, 3, 4, 10, 11, 12} |=> busy_o ##1 !busy_o && !skip_o)
		else $error("alu op not one cycle");
	skip_slot_a: assert property (
		ex && op inside {5, 6, 7} |=> busy_o && !skip_o ##1 (skip_o || !busy_o))
		else $error("skip op timing wrong");
	skip_pair_a: assert property (
		skip_o |-> dummy_o && busy_o ##1 !busy_o && !skip_o) else $error("dummy cycle wrong");
	table_timing_a: assert property (
		ex && op inside {8, 9} |=> busy_o && !prog_rd_o ##1 busy_o && prog_rd_o
		##1 busy_o && !prog_rd_o ##1 !busy_o)
		else $error("table read timing wrong");
	last_page_a: assert property (
		ex && op == 4'h9 |=> ##1 prog_addr_o[11:8] == MIE_LAST_PAGE) else $error("not last page");
	addr_hold_a: assert property ($changed(prog_addr_o) |-> prog_rd_o)
		else $error("program address moved");
	rdata_idle_a: assert property (!(apb_i.psel && apb_i.penable) |-> apb_o.prdata == MIE_RD_ZERO)
		else $error("read data outside access");
	slverr_access_a: assert property (apb_o.pslverr |-> apb_i.psel && apb_i.penable)
		else $error("error outside access");
	cover property (skip_o);
	cover property (prog_rd_o && prog_addr_o[11:8] == MIE_LAST_PAGE);
	cover property (apb_o.pslverr);
endmodule

bind mie_exec mie_exec_sva #(.DMEM_DEPTH(DMEM_DEPTH)) chk_u (.clk_i(clk_i),
	.reset_n_i(reset_n_i), .apb_i(apb_i), .apb_o(apb_o), .prog_addr_o(prog_addr_o),
	.prog_rd_o(prog_rd_o), .prog_data_i(prog_data_i), .skip_o(skip_o), .dummy_o(dummy_o),
	.busy_o(busy_o));

// ### verif/tb_mie_exec.sv
// testbench: random instructions checked through register reads
module tb_mie_exec import mie_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, reset_n_i = 0, prog_rd_o, skip_o, dummy_o, busy_o, sk;
	mie_apb_req_t apb_i = '0;
	mie_apb_rsp_t apb_o;
	logic [11:0] prog_addr_o;
	logic [14:0] prog_data_i = '0;
	logic [32:0] expq[$];
	int err_count = 0, compares = 0, cyc = 0, seed = 16;
	logic [7:0] w, m, x, y, r, v, ad, tp;
	logic [6:0] t = '0;
	logic [8:0] s;
	logic [4:0] h;
	logic [3:0] fl, pg, op;
	logic [2:0] b;

	mie_exec dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .apb_i(apb_i), .apb_o(apb_o),
		.prog_addr_o(prog_addr_o), .prog_rd_o(prog_rd_o), .prog_data_i(prog_data_i),
		.skip_o(skip_o), .dummy_o(dummy_o), .busy_o(busy_o));

	function automatic logic [14:0] pw(input logic [11:0] a);
		return {a[10:4], a[7:0] ^ 8'hA5};
	endfunction
	always #20 clk_i = ~clk_i;
	// word valid only in the cycle after the strobe, a moving pattern otherwise
	always @(posedge clk_i) prog_data_i <= prog_rd_o ? pw(prog_addr_o) : ~prog_data_i;
	// a hang is cut off far above the few thousand cycles needed
	always @(posedge clk_i) if (++cyc == 20000) begin
		err_count++;
		complete_run;
	end

	task automatic complete_run;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(string nm, logic [32:0] seen, logic [32:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// monitor: each taken read pops the oldest note, sampled before its edge
	always @(posedge clk_i) if (apb_i.psel && apb_i.penable && !apb_i.pwrite && apb_o.pready)
		chk($sformatf("reg %h", apb_i.paddr), {apb_o.pslverr, apb_o.prdata}, expq.pop_front());
	task automatic xfer(logic wr, logic [7:0] a, logic [31:0] d);
		@(posedge clk_i);
		apb_i <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk_i);
		apb_i.penable <= 1'b1;
		@(posedge clk_i);
		while (apb_o.pready !== 1'b1) @(posedge clk_i);
		apb_i.psel <= 1'b0;
		apb_i.penable <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [32:0] e);
		expq.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask

	initial begin
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1'b1;
		for (int a = 4; a <= 24; a += 4) rd(8'(a), 33'h0);
		rd(8'h20, {1'b1, 32'h0});
		// every opcode but the no-op about eight times; a quarter of the bytes are zero to force skips
		for (int n = 0; n < 104; n++) begin
			{w, x, tp, pg, fl, b} = 35'({$random(seed), $random(seed)});
			m = ($random(seed) % 4 == 0) ? 8'h00 : 8'($random(seed));
			ad = 8'({$random(seed)} % 224);
			op = 4'(n % 12 + 1);
			xfer(1'b1, MIE_OFS_WORK, {24'h0, w});
			xfer(1'b1, MIE_OFS_STAT, {28'h0, fl});
			xfer(1'b1, MIE_OFS_TPTR, {24'h0, tp});
			xfer(1'b1, MIE_OFS_PAGE, {28'h0, pg});
			xfer(1'b1, MIE_OFS_MADR, {24'h0, ad});
			xfer(1'b1, MIE_OFS_MDAT, {24'h0, m});
			xfer(1'b1, MIE_OFS_EXEC, {8'h0, x, 1'b0, b, ad, op});
			y = (op == 2 || op == 12) ? x : m;
			s = {1'b0, w} + {1'b0, ~y} + 9'h1;
			h = {1'b0, w[3:0]} + {1'b0, ~y[3:0]} + 5'h1;
			{r, v, sk} = {m, w, 1'b0};
			case (op)
				1, 2: begin
					if (op == 1) r = s[7:0];
					else v = s[7:0];
					fl = {(w[7] ^ y[7]) & (s[7] ^ w[7]), s[7:0] == 8'h0, h[4], s[8]};
				end
				3: r = {m[3:0], m[7:4]};
				4: v = {m[3:0], m[7:4]};
				5: sk = m == 8'h0;
				6: {v, sk} = {m, m == 8'h0};
				7: sk = !m[b];
				8, 9: {t, r} = pw({op == 9 ? 4'hF : pg, tp});
				default: begin
					if (op == 11) r = w ^ y;
					else v = w ^ y;
					fl[2] = (w ^ y) == 8'h0;
				end
			endcase
			rd(MIE_OFS_WORK, {25'h0, v});
			rd(MIE_OFS_MDAT, {25'h0, r});
			rd(MIE_OFS_STAT, {27'h0, sk, 1'b0, fl});
			rd(MIE_OFS_THI, {26'h0, t});
		end
		// the high latch ignores writes
		xfer(1'b1, MIE_OFS_THI, {25'h0, ~t});
		rd(MIE_OFS_THI, {26'h0, t});
		complete_run;
	end
endmodule
